// *** bench/desc_map_checker.sv ***
/* Port checker for the descriptor mapping engine.
   Assumes binding onto the top module; sees its ports only. */
`timescale 1ns/1ps
module desc_map_checker (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [1:0] buffer_mode,
  input wire logic [15:0] table_base,
  input wire logic token_valid,
  input wire logic [3:0] token_ep,
  input wire logic token_tx,
  input wire logic grant_valid,
  input wire logic [15:0] grant_addr,
  input wire logic grant_odd,
  input wire logic refused,
  input wire logic release_done,
  input wire logic busy,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [15:0] mem_addr,
  input wire logic [15:0] mem_wdata,
  input wire logic [15:0] mem_rdata,
  input wire logic mem_ack
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  logic take; // Token accepted this edge
  assign take = token_valid && !busy;
  a_token_read: assert property (take |=> mem_req && !mem_we && busy)
    else $error("token did not start a read");
  a_req_holds: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr))
    else $error("request dropped or moved before ack");
  a_owns_grant: assert property (mem_req && !mem_we && mem_ack |=>
    grant_valid == $past(mem_rdata[7]) && refused == !$past(mem_rdata[7]))
    else $error("grant does not follow owns flag");
  a_wb_clears: assert property (mem_req && mem_we |-> !mem_wdata[7])
    else $error("write-back keeps owns flag");
  a_release_ends: assert property (mem_req && mem_we && mem_ack |=> release_done && !busy)
    else $error("no release after write ack");
  a_slot_range: assert property (take |=> mem_addr - table_base < 16'h0200)
    else $error("descriptor address outside table");
  a_mode0_slot: assert property (take && buffer_mode == 2'h0 |=>
    mem_addr - table_base == {8'h00, $past(token_ep), $past(token_tx), 3'h0})
    else $error("mode 0 slot wrong");
  a_mode2_slot: assert property (take && buffer_mode == 2'h2 |=>
    (mem_addr - table_base) >> 4 == {11'h000, $past(token_ep), $past(token_tx)})
    else $error("mode 2 slot wrong");
  a_single_even: assert property (grant_valid && buffer_mode == 2'h0 |-> !grant_odd)
    else $error("odd buffer without ping-pong");
  a_grant_addr: assert property (grant_valid |-> grant_addr == $past(mem_addr))
    else $error("grant address differs from fetch");
  c_odd: cover property (grant_valid && grant_odd);
  c_refused: cover property (refused);
  c_release: cover property (release_done);
endmodule
bind usb_descriptor_dma_map desc_map_checker u_desc_map_checker (.*);

// *** bench/desc_memory.sv ***
/* Data memory partner holding the descriptor table.
   Assumes a table base with bits 11..0 clear; ack after a set delay. */
`timescale 1ns/1ps
module desc_memory (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [15:0] mem_addr,
  input wire logic [15:0] mem_wdata,
  input wire logic [3:0] delay,
  output logic [15:0] mem_rdata,
  output logic mem_ack
);
  logic [15:0] words [0:511]; // One contiguous region, a status word per slot
  logic [3:0] cnt; // Wait cycles spent
  // Idle read data churns so a stale word never looks valid
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt <= 4'h0;
      mem_ack <= 1'b0;
      mem_rdata <= 16'hA5A5;
    end else begin
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
      if (mem_req && !mem_ack) begin
        if (cnt == delay) begin
          cnt <= 4'h0;
          mem_ack <= 1'b1;
          if (mem_we) words[mem_addr[11:3]] <= mem_wdata;
          else mem_rdata <= words[mem_addr[11:3]];
        end else cnt <= cnt + 4'h1;
      end
    end
  end
endmodule

// *** bench/testbench.sv ***
/* Self-checking bench for the descriptor mapping engine.
   Assumes the memory partner model; drives inputs on falling edges. */
`timescale 1ns/1ps
module testbench;
  logic clk = 0, reset_n = 0, parity_clear = 0, token_valid = 0, token_tx = 0, xfer_done = 0;
  logic [1:0] buffer_mode = 2'h0;
  logic [15:0] table_base = 16'h1000, xfer_status = 16'h0000, grant_addr, grant_status;
  logic [15:0] mem_addr, mem_wdata, mem_rdata;
  logic [3:0] token_ep = 4'h0, delay = 4'h0;
  logic grant_valid, grant_odd, refused, release_done, busy, mem_req, mem_we, mem_ack;
  logic par [0:31]; // Expected odd/even per endpoint and direction
  int n_errors = 0, n_tests = 0, cycles = 0;
  always #10 clk = ~clk;
  usb_descriptor_dma_map u_usb_descriptor_dma_map (.*);
  desc_memory u_desc_memory (.*);
  // Cut a hang short
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      results();
    end
  end
  task automatic check(input string what, input logic [15:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic results();
    if (n_errors == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Expected slot for mode, endpoint, direction and parity
  function automatic int slot(input logic [1:0] m, input int ep, tx, odd);
    case (m)
      2'h0: return 2 * ep + tx;
      2'h1: return ep == 0 ? (tx ? 2 : odd) : 2 * ep + 1 + tx;
      2'h2: return 4 * ep + 2 * tx + odd;
      default: return ep == 0 ? tx : 4 * ep - 2 + 2 * tx + odd;
    endcase
  endfunction
  // One token, then grant and release, or refusal
  task automatic xact(input int ep, tx, input logic own);
    int s, k;
    logic odd;
    logic pp;
    odd = par[2 * ep + tx];
    s = slot(buffer_mode, ep, tx, odd);
    pp = buffer_mode == 2'h2 || (buffer_mode == 2'h1 && ep == 0 && tx == 0)
      || (buffer_mode == 2'h3 && ep != 0);
    u_desc_memory.words[s] = {8'h5A, own, 7'h11};
    @(negedge clk);
    token_valid = 1;
    token_ep = ep[3:0];
    token_tx = tx[0];
    @(negedge clk) token_valid = 0;
    for (k = 0; k < 20 && grant_valid !== 1 && refused !== 1; k++) @(negedge clk);
    check("granted", 16'(grant_valid), 16'(own));
    check("refused", 16'(refused), 16'(!own));
    check("busy", 16'(busy), 16'(own));
    if (own) begin
      check("address", grant_addr, 16'h1000 + 16'(s * 8));
      check("odd", 16'(grant_odd), 16'(odd));
      check("status", grant_status, {8'h5A, own, 7'h11});
      xfer_done = 1;
      token_valid = 1; // Must be ignored while busy
      token_ep = 4'(ep ^ 1);
      xfer_status = 16'hFF83;
      @(negedge clk);
      xfer_done = 0;
      token_valid = 0;
      for (k = 0; k < 20 && release_done !== 1; k++) @(negedge clk);
      check("released", 16'(release_done), 16'h0001);
      check("idle", 16'(busy), 16'h0000);
      check("written", u_desc_memory.words[s], 16'hFF03);
      if (pp) par[2 * ep + tx] = !odd;
    end else check("kept", u_desc_memory.words[s], 16'h5A11);
  endtask
  // Every mode, every endpoint, three passes, memory slower each mode
  task automatic t_modes();
    for (int m = 0; m < 4; m++) begin
      @(negedge clk);
      buffer_mode = 2'(m);
      delay = 4'(m);
      parity_clear = 1;
      @(negedge clk) parity_clear = 0;
      foreach (par[i]) par[i] = 0;
      for (int p = 0; p < 3; p++)
        for (int e = 0; e < 16; e++)
          for (int t = 0; t < 2; t++) xact(e, t, 1);
    end
  endtask
  // Refusals between grants leave the pairing alone
  task automatic t_refuse();
    for (int i = 0; i < 4; i++) xact(5, 1, i[0]);
  endtask
  initial begin
    repeat (20) @(negedge clk);
    reset_n = 1;
    t_modes();
    t_refuse();
    results();
  end
endmodule

// *** src/desc_index_map.sv ***
/*
  Maps endpoint, direction and even/odd parity to a descriptor slot.
  Assumes inputs are stable in the cycle they are used; purely combinational.
*/
`timescale 1ns/1ps
module desc_index_map (
  input wire logic [1:0] buffer_mode,
  input wire logic [3:0] endpoint,
  input wire logic tx,
  input wire logic odd,
  output logic [5:0] index,
  output logic ping_pong
);
  logic [6:0] ep7; // Endpoint widened for arithmetic
  logic [6:0] raw; // Unclipped slot number
  assign ep7 = {3'h0, endpoint};

  // Slot depends on mode, endpoint, direction and, for ping-pong slots, the odd input
  always_comb begin // R8
    raw = 7'h00;
    ping_pong = 1'b0;
    case (buffer_mode)
      desc_map_pkg::MODE_SINGLE: begin
        raw = 7'((ep7 << 1) + {6'h00, tx}); // R3
      end
      desc_map_pkg::MODE_PP_EP0_RX: begin
        if (endpoint == 4'h0 && !tx) begin
          raw = {6'h00, odd}; // R4
          ping_pong = 1'b1;
        end else if (endpoint == 4'h0) begin
          raw = 7'h02; // R4
        end else begin
          raw = 7'((ep7 << 1) + 7'h01 + {6'h00, tx}); // R4
        end
      end
      desc_map_pkg::MODE_PP_ALL: begin
        raw = 7'((ep7 << 2) + {5'h00, tx, odd}); // R5 R7
        ping_pong = 1'b1;
      end
      desc_map_pkg::MODE_PP_NOT_EP0: begin
        if (endpoint == 4'h0) begin
          raw = {6'h00, tx}; // R6
        end else begin
          raw = 7'((ep7 << 2) - 7'h02 + {5'h00, tx, odd}); // R6 R7
          ping_pong = 1'b1;
        end
      end
      default: begin
        raw = 7'h00;
      end
    endcase
  end

  assign index = raw[5:0];
endmodule

// *** src/desc_map_pkg.sv ***
/*
  Constants shared by the descriptor mapping engine and its index mapper.
  Assumes a 16-bit data memory, byte addressed, reached over one DMA port.
*/
// Operation
// R1: Own DMA master fetches descriptors, no core.
// R2: Memory holds one contiguous descriptor table.
// R3: Mode 0: receive 2n, transmit 2n+1.
// R4: Mode 1: endpoint 0 receive pairs 0/1.
// R5: Mode 2: 4n..4n+3 on every endpoint.
// R6: Mode 3: endpoint 0 single, others paired.
// R7: Lower slot even, higher odd, alternating.
// R8: Slot fixed by buffering mode alone. The code also uses endpoint, direction and parity.
// R9: Touch descriptor only while DMA owns it.
// R10: Address is base plus index times size.
package desc_map_pkg;
  // Buffering modes
  localparam logic [1:0] MODE_SINGLE = 2'h0;
  localparam logic [1:0] MODE_PP_EP0_RX = 2'h1;
  localparam logic [1:0] MODE_PP_ALL = 2'h2;
  localparam logic [1:0] MODE_PP_NOT_EP0 = 2'h3;
  // Memory path and slot index widths
  localparam int ADDR_W = 16;
  localparam int DATA_W = 16;
  localparam int INDEX_W = 6;
  // Bytes per buffer_descriptor, as a left shift of the index
  localparam int DESC_SHIFT = 3;
  // Byte offset of the descriptor_status_word inside a descriptor
  localparam logic [15:0] STAT_OFFSET = 16'h0000;
  // Position of dma_owns_flag inside the descriptor_status_word
  localparam int OWNS_BIT = 7;
  // Reset values
  localparam logic [15:0] ADDR_RESET = 16'h0000;
  localparam logic [15:0] DATA_RESET = 16'h0000;
  localparam logic [31:0] PARITY_RESET = 32'h00000000;
endpackage

// *** src/usb_descriptor_dma_map.sv ***
/*
  Descriptor fetch and release engine for the USB serial engine's own DMA.
  Assumes the serial engine on the same clock gives tokens and completions,
  and that data memory answers each request with a one-cycle ack.
*/
`timescale 1ns/1ps
module usb_descriptor_dma_map (
  input wire logic clk,
  input wire logic reset_n,
  // Configuration
  input wire logic [1:0] buffer_mode,
  input wire logic [15:0] table_base,
  input wire logic parity_clear,
  // Serial engine side
  input wire logic token_valid,
  input wire logic [3:0] token_ep,
  input wire logic token_tx,
  input wire logic xfer_done,
  input wire logic [15:0] xfer_status,
  output logic grant_valid,
  output logic [15:0] grant_addr,
  output logic grant_odd,
  output logic [15:0] grant_status,
  output logic refused,
  output logic release_done,
  output logic busy,
  // Dedicated DMA master to data memory
  output logic mem_req,
  output logic mem_we,
  output logic [15:0] mem_addr,
  output logic [15:0] mem_wdata,
  input wire logic [15:0] mem_rdata,
  input wire logic mem_ack
);
  // Engine states
  typedef enum logic [1:0] {IDLE, FETCH, HOLD, STORE} state_t;

  state_t state; // Current state
  state_t next_state;
  logic [3:0] ep; // Latched endpoint
  logic [3:0] next_ep;
  logic tx; // Latched direction
  logic next_tx;
  logic [15:0] desc_addr; // Latched descriptor address
  logic [15:0] next_desc_addr;
  logic [31:0] parity; // Even/odd per endpoint and direction
  logic [31:0] next_parity;
  logic next_grant_valid;
  logic [15:0] next_grant_addr;
  logic next_grant_odd;
  logic [15:0] next_grant_status;
  logic next_refused;
  logic next_release_done;
  logic next_busy;
  logic next_mem_req;
  logic next_mem_we;
  logic [15:0] next_mem_addr;
  logic [15:0] next_mem_wdata;
  logic [5:0] slot; // Mapped slot for incoming token
  logic slot_pp; // Incoming direction is double-buffered
  logic [5:0] held_slot; // Mapped slot for latched endpoint
  logic held_pp; // Latched direction is double-buffered
  logic [4:0] tok_sel; // Parity bit of incoming token
  logic [4:0] held_sel; // Parity bit of latched endpoint
  logic [15:0] slot_addr; // Address of incoming token's descriptor

  assign tok_sel = {token_ep, token_tx};
  assign held_sel = {ep, tx};

  // Slot for the token being taken
  desc_index_map map_token (
    .buffer_mode(buffer_mode),
    .endpoint(token_ep),
    .tx(token_tx),
    .odd(parity[tok_sel]),
    .index(slot),
    .ping_pong(slot_pp)
  );

  // Ping-pong property of the endpoint in service
  desc_index_map map_held (
    .buffer_mode(buffer_mode),
    .endpoint(ep),
    .tx(tx),
    .odd(parity[held_sel]),
    .index(held_slot),
    .ping_pong(held_pp)
  );

  // Table base plus index times descriptor size
  assign slot_addr = 16'(table_base + ({10'h000, slot} << desc_map_pkg::DESC_SHIFT)); // R10 R2

  // Next-state logic of the engine
  always_comb begin
    next_state = state;
    next_ep = ep;
    next_tx = tx;
    next_desc_addr = desc_addr;
    next_parity = parity;
    next_grant_valid = 1'b0;
    next_grant_addr = grant_addr;
    next_grant_odd = grant_odd;
    next_grant_status = grant_status;
    next_refused = 1'b0;
    next_release_done = 1'b0;
    next_busy = busy;
    next_mem_req = mem_req;
    next_mem_we = mem_we;
    next_mem_addr = mem_addr;
    next_mem_wdata = mem_wdata;
    // Clear all parities back to even
    if (parity_clear) begin
      next_parity = desc_map_pkg::PARITY_RESET;
    end
    case (state)
      IDLE: begin
        // Take a token, read its status word over our own master
        if (token_valid) begin
          next_ep = token_ep;
          next_tx = token_tx;
          next_desc_addr = slot_addr;
          next_grant_odd = slot_pp & parity[tok_sel]; // R7
          next_mem_req = 1'b1; // R1
          next_mem_we = 1'b0;
          next_mem_addr = 16'(slot_addr + desc_map_pkg::STAT_OFFSET);
          next_busy = 1'b1;
          next_state = FETCH;
        end
      end
      FETCH: begin
        // Status word arrived
        if (mem_ack) begin
          next_mem_req = 1'b0;
          next_grant_status = mem_rdata;
          if (mem_rdata[desc_map_pkg::OWNS_BIT]) begin
            // Owned by the DMA: hand the descriptor over
            next_grant_valid = 1'b1; // R9
            next_grant_addr = desc_addr;
            next_state = HOLD;
          end else begin
            // Software still owns it: leave it untouched
            next_refused = 1'b1; // R9
            next_busy = 1'b0;
            next_state = IDLE;
          end
        end
      end
      HOLD: begin
        // Engine finished: give the descriptor back
        if (xfer_done) begin
          next_mem_req = 1'b1; // R1
          next_mem_we = 1'b1;
          next_mem_addr = 16'(desc_addr + desc_map_pkg::STAT_OFFSET);
          next_mem_wdata = xfer_status;
          next_mem_wdata[desc_map_pkg::OWNS_BIT] = 1'b0; // R9
          next_state = STORE;
        end
      end
      STORE: begin
        // Write-back accepted: flip, applied on top of any clear this cycle
        if (mem_ack) begin
          next_mem_req = 1'b0;
          next_mem_we = 1'b0;
          next_release_done = 1'b1;
          next_busy = 1'b0;
          if (held_pp) begin
            next_parity[held_sel] = ~next_parity[held_sel]; // R7
          end
          next_state = IDLE;
        end
      end
      default: begin
        next_state = IDLE;
      end
    endcase
  end

  // Register the engine
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= IDLE;
      ep <= 4'h0;
      tx <= 1'b0;
      desc_addr <= desc_map_pkg::ADDR_RESET;
      parity <= desc_map_pkg::PARITY_RESET;
      grant_valid <= 1'b0;
      grant_addr <= desc_map_pkg::ADDR_RESET;
      grant_odd <= 1'b0;
      grant_status <= desc_map_pkg::DATA_RESET;
      refused <= 1'b0;
      release_done <= 1'b0;
      busy <= 1'b0;
      mem_req <= 1'b0;
      mem_we <= 1'b0;
      mem_addr <= desc_map_pkg::ADDR_RESET;
      mem_wdata <= desc_map_pkg::DATA_RESET;
    end else begin
      state <= next_state;
      ep <= next_ep;
      tx <= next_tx;
      desc_addr <= next_desc_addr;
      parity <= next_parity;
      grant_valid <= next_grant_valid;
      grant_addr <= next_grant_addr;
      grant_odd <= next_grant_odd;
      grant_status <= next_grant_status;
      refused <= next_refused;
      release_done <= next_release_done;
      busy <= next_busy;
      mem_req <= next_mem_req;
      mem_we <= next_mem_we;
      mem_addr <= next_mem_addr;
      mem_wdata <= next_mem_wdata;
    end
  end

  // Slot of the latched endpoint is only used for its ping-pong flag
  logic unused_slot;
  assign unused_slot = ^held_slot;
endmodule
